// ===== include/rgp_pkg.sv
// Shared constants and types for the PHY-side reduced gigabit MAC interface
`default_nettype none
package rgp_pkg;

  // ==========================================================
  // Clock rates and derived divider count
  // ==========================================================
  localparam int CLK_SYS_MHZ = 250;
  localparam int LINK_CLK_MHZ = 125;
  // System cycles per half period of the generated receive clock
  localparam int RX_HALF_RAW = CLK_SYS_MHZ / (2 * LINK_CLK_MHZ);
  localparam int RX_HALF_CYC = (RX_HALF_RAW < 1) ? 1 : RX_HALF_RAW;

  // ==========================================================
  // Pin field widths and in-band status layout
  // ==========================================================
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int STAT_DUPLEX_BIT = 3;
  localparam int STAT_LINK_BIT = 0;
  localparam logic [3:0] FALSE_CARRIER_NIB = 4'hE;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================
  // Buffer geometry
  // ==========================================================
  localparam int RX_FIFO_DEPTH = 16;

  // ==========================================================
  // Types
  // ==========================================================
  // Kind of one byte period on either direction
  typedef enum logic [1:0] {
    RGP_IDLE,
    RGP_DATA,
    RGP_ERR,
    RGP_FALSE_CARRIER
  } rgp_kind_t;

  // One byte period: kind plus byte, low nibble first on the wire
  typedef struct packed {
    rgp_kind_t kind;
    logic [7:0] data;
  } rgp_sym_t;

  localparam int SYM_W = $bits(rgp_sym_t);

  // Transmit pins as driven by the MAC
  typedef struct packed {
    logic clk;
    logic ctl;
    logic [3:0] d;
  } rgp_tx_pins_t;

endpackage
`default_nettype wire

// ===== hw/rgp_fifo.sv
// Receive symbol FIFO with registered read data and registered ready
`timescale 1ns/100ps
`default_nettype none
module rgp_fifo
  import rgp_pkg::*;
#(
  parameter int WIDTH = SYM_W,
  parameter int DEPTH = RX_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic in_ready_r, in_ready_nxt, out_valid_r, out_valid_nxt;
  logic [WIDTH-1:0] out_data_r, out_data_nxt;
  logic push, load;

  // ==========================================================
  // Pointer, count and output stage next values
  // ==========================================================
  always_comb begin
    push = in_valid && in_ready_r;
    load = (!out_valid_r || out_ready) && (cnt_r != '0);
    wr_ptr_nxt = push ? wr_ptr_r + PTR_ONE : wr_ptr_r;
    rd_ptr_nxt = load ? rd_ptr_r + PTR_ONE : rd_ptr_r;
    cnt_nxt = cnt_r;
    if (push && !load) begin
      cnt_nxt = cnt_r + CNT_ONE;
    end else if (load && !push) begin
      cnt_nxt = cnt_r - CNT_ONE;
    end
    in_ready_nxt = (cnt_nxt < DEPTH_C);
    out_data_nxt = load ? mem[rd_ptr_r] : out_data_r;
    out_valid_nxt = load || (out_valid_r && !out_ready);
  end

  // Storage write, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // State registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      in_ready_r <= in_ready_nxt;
      out_valid_r <= out_valid_nxt;
      out_data_r <= out_data_nxt;
    end
  end

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

endmodule
`default_nettype wire

// ===== hw/rgp_tx_sampler.sv
// Two-stage synchroniser and edge finder for the MAC transmit pins
`timescale 1ns/100ps
`default_nettype none
module rgp_tx_sampler
  import rgp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw pins from the MAC
  input wire rgp_tx_pins_t pins,
  // Synchronised view
  output rgp_tx_pins_t pins_sync,
  output logic clk_rise,
  output logic clk_fall
);

  rgp_tx_pins_t meta_r, sync_r, prev_r;

  // ==========================================================
  // Synchroniser chain; first stage feeds only the second
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edge detection on the settled stages
  assign clk_rise = sync_r.clk && !prev_r.clk;
  assign clk_fall = !sync_r.clk && prev_r.clk;
  assign pins_sync = sync_r;

endmodule
`default_nettype wire

// ===== hw/rgp_top.sv
// PHY-side reduced gigabit MAC interface: transmit decode, receive encode
`timescale 1ns/100ps
`default_nettype none
// Function
// - Both directions use the revision 2.0 scheme of four data lines, one control, one clock.
// - Control carries two values per clock period and is taken on both clock edges.
// - At 1 Gbps the transmit and receive clocks both run at 125 MHz.
// - Transmit control 0/0 is inter-frame, 1/0 data, 1/1 error, 0/1 reserved, any data.
// - Receive control is driven 0/0 idle, 1/0 data, 1/1 errored data, 0/1 with 1110 false carrier.
// - During receive inter-frame the data lines carry in-band status instead of idle data.
// - In-band status bit 3 is duplex and bit 0 is link.
module rgp_top
  import rgp_pkg::*;
#(
  parameter int RX_HALF = RX_HALF_CYC,
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Transmit pins from the MAC
  input wire logic tx_clk,
  input wire logic tx_ctl,
  input wire logic [3:0] tx_d,
  // Receive pins to the MAC
  output logic rx_clk,
  output logic rx_ctl,
  output logic [3:0] rx_d,
  // Link state from the transceiver core
  input wire logic link_up,
  input wire logic full_duplex,
  // Receive symbols from the transceiver core
  input wire logic rx_in_valid,
  input wire rgp_sym_t rx_in_sym,
  output logic rx_in_ready,
  // Transmit symbols to the transceiver core
  output logic tx_out_valid,
  output rgp_sym_t tx_out_sym,
  output logic tx_frame
);

  localparam int HCW = (RX_HALF > 1) ? $clog2(RX_HALF) : 1;
  localparam logic [HCW-1:0] HALF_LAST = HCW'(RX_HALF - 1);
  localparam logic [HCW-1:0] HALF_ONE = HCW'(1);

  // ==========================================================
  // Encoding helpers
  // ==========================================================
  // Control pair to kind; the reserved pair reads as inter-frame
  function automatic rgp_kind_t tx_kind(input logic ctl_r, input logic ctl_f);
    rgp_kind_t k;
    k = RGP_IDLE;
    unique case ({ctl_r, ctl_f})
      2'h0: k = RGP_IDLE;
      2'h1: k = RGP_IDLE; // Reserved pair
      2'h2: k = RGP_DATA;
      2'h3: k = RGP_ERR;
    endcase
    return k;
  endfunction

  // Control value for one half of a receive period
  function automatic logic rx_ctl_of(input rgp_kind_t k, input logic fall_half);
    logic v;
    v = 1'b0;
    unique case (k)
      RGP_IDLE: v = 1'b0;
      RGP_DATA: v = !fall_half;
      RGP_ERR: v = 1'b1;
      RGP_FALSE_CARRIER: v = fall_half;
    endcase
    return v;
  endfunction

  // In-band status nibble for inter-frame periods
  function automatic logic [3:0] status_of(input logic link, input logic duplex);
    logic [3:0] s;
    s = NIB_ZERO;
    s[STAT_DUPLEX_BIT] = duplex;
    s[STAT_LINK_BIT] = link;
    return s;
  endfunction

  // Nibble for one half of a receive period, low nibble first
  function automatic logic [3:0] rx_nib_of(input rgp_sym_t s, input logic fall_half);
    logic [3:0] n;
    n = fall_half ? s.data[7:4] : s.data[3:0];
    return n;
  endfunction

  // ==========================================================
  // Transmit path: synchronise pins and find clock edges
  // ==========================================================
  rgp_tx_pins_t tx_pins, tx_sync;
  logic tx_rise, tx_fall;

  // Pins gathered into one carrier
  assign tx_pins = '{clk: tx_clk, ctl: tx_ctl, d: tx_d};

  rgp_tx_sampler i_rgp_tx_sampler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pins(tx_pins),
    .pins_sync(tx_sync),
    .clk_rise(tx_rise),
    .clk_fall(tx_fall)
  );

  // ==========================================================
  // Transmit path: rising half capture
  // ==========================================================
  // First control value and low nibble
  logic tx_ctl_rise_r, tx_ctl_rise_nxt;
  logic [3:0] tx_lo_r, tx_lo_nxt;

  // rising half holds first control value and low nibble
  always_comb begin
    tx_ctl_rise_nxt = tx_ctl_rise_r;
    tx_lo_nxt = tx_lo_r;
    if (tx_rise) begin
      tx_ctl_rise_nxt = tx_sync.ctl;
      tx_lo_nxt = tx_sync.d;
    end
  end

  // Rising half registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_ctl_rise_r <= 1'b0;
      tx_lo_r <= NIB_ZERO;
    end else begin
      tx_ctl_rise_r <= tx_ctl_rise_nxt;
      tx_lo_r <= tx_lo_nxt;
    end
  end

  // ==========================================================
  // Transmit path: falling half decode
  // ==========================================================
  // Decoded symbol, its pulse and the frame level
  rgp_sym_t tx_sym_r, tx_sym_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic tx_frame_r, tx_frame_nxt;

  // decode the pair once the falling half arrives
  always_comb begin
    tx_sym_nxt = tx_sym_r;
    tx_valid_nxt = 1'b0;
    tx_frame_nxt = tx_frame_r;
    if (tx_fall) begin
      tx_sym_nxt.kind = tx_kind(tx_ctl_rise_r, tx_sync.ctl);
      tx_sym_nxt.data = {tx_sync.d, tx_lo_r};
      tx_valid_nxt = 1'b1;
      tx_frame_nxt = (tx_sym_nxt.kind != RGP_IDLE);
    end
  end

  // Decoded symbol registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_sym_r <= '{kind: RGP_IDLE, data: BYTE_ZERO};
      tx_valid_r <= 1'b0;
      tx_frame_r <= 1'b0;
    end else begin
      tx_sym_r <= tx_sym_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_frame_r <= tx_frame_nxt;
    end
  end

  // Core-side outputs straight from registers
  assign tx_out_valid = tx_valid_r;
  assign tx_out_sym = tx_sym_r;
  assign tx_frame = tx_frame_r;

  // ==========================================================
  // Receive path: symbol buffer
  // ==========================================================
  logic fifo_out_valid, fifo_take;
  logic [SYM_W-1:0] fifo_out_data;
  rgp_sym_t fifo_sym;

  rgp_fifo #(
    .WIDTH(SYM_W),
    .DEPTH(FIFO_DEPTH)
  ) i_rgp_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(rx_in_valid),
    .in_data(rx_in_sym),
    .in_ready(rx_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_take)
  );

  // Buffer word back to its symbol form
  assign fifo_sym = rgp_sym_t'(fifo_out_data);

  // ==========================================================
  // Receive path: clock divider
  // ==========================================================
  // Divider state and half strobes
  logic [HCW-1:0] half_cnt_r, half_cnt_nxt;
  logic rx_clk_r, rx_clk_nxt;
  logic toggle, half_rise, half_fall;

  always_comb begin
    toggle = (half_cnt_r == HALF_LAST);
    half_cnt_nxt = half_cnt_r + HALF_ONE;
    rx_clk_nxt = rx_clk_r;
    if (toggle) begin
      half_cnt_nxt = '0;
      rx_clk_nxt = !rx_clk_r;
    end
    half_rise = toggle && !rx_clk_r;
    half_fall = toggle && rx_clk_r;
  end

  // Divider registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      half_cnt_r <= '0;
      rx_clk_r <= 1'b0;
    end else begin
      half_cnt_r <= half_cnt_nxt;
      rx_clk_r <= rx_clk_nxt;
    end
  end

  // ==========================================================
  // Receive path: symbol choice for each period
  // ==========================================================
  // Symbol on the pins and the candidate for the next period
  rgp_sym_t cur_sym_r, cur_sym_nxt;
  rgp_sym_t next_sym;
  logic [3:0] status_nib;

  // Next symbol, held for the whole period
  always_comb begin
    status_nib = status_of(link_up, full_duplex);
    next_sym = '{kind: RGP_IDLE, data: {status_nib, status_nib}};
    if (fifo_out_valid && fifo_sym.kind != RGP_IDLE) begin
      next_sym = fifo_sym;
    end
    // false carrier only with its fixed code
    if (next_sym.kind == RGP_FALSE_CARRIER) begin
      next_sym.data = {FALSE_CARRIER_NIB, FALSE_CARRIER_NIB};
    end
    // Idle words in the buffer are consumed like any other
    fifo_take = 1'b0;
    cur_sym_nxt = cur_sym_r;
    if (half_rise) begin
      fifo_take = fifo_out_valid;
      cur_sym_nxt = next_sym;
    end
  end

  // Current symbol register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_sym_r <= '{kind: RGP_IDLE, data: BYTE_ZERO};
    end else begin
      cur_sym_r <= cur_sym_nxt;
    end
  end

  // ==========================================================
  // Receive path: double-rate pin driver
  // ==========================================================
  // Pin registers, edge aligned with the receive clock
  logic rx_ctl_r, rx_ctl_nxt;
  logic [3:0] rx_d_r, rx_d_nxt;

  // Pin values for the half that starts at the next edge
  always_comb begin
    rx_ctl_nxt = rx_ctl_r;
    rx_d_nxt = rx_d_r;
    // rising half: new symbol, low nibble
    if (half_rise) begin
      rx_ctl_nxt = rx_ctl_of(next_sym.kind, 1'b0);
      rx_d_nxt = rx_nib_of(next_sym, 1'b0);
    end
    // falling half: second control value, high nibble
    if (half_fall) begin
      rx_ctl_nxt = rx_ctl_of(cur_sym_r.kind, 1'b1);
      rx_d_nxt = rx_nib_of(cur_sym_r, 1'b1);
    end
  end

  // Pin registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_ctl_r <= 1'b0;
      rx_d_r <= NIB_ZERO;
    end else begin
      rx_ctl_r <= rx_ctl_nxt;
      rx_d_r <= rx_d_nxt;
    end
  end

  assign rx_clk = rx_clk_r;
  assign rx_ctl = rx_ctl_r;
  assign rx_d = rx_d_r;

endmodule
`default_nettype wire

// ===== testbench/rgp_top_assertions.sv
// Checker for the pins of both directions
`timescale 1ns/100ps
`default_nettype none
module rgp_top_assertions
  import rgp_pkg::*;
#(
  parameter int RX_HALF = RX_HALF_CYC,
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic rx_ctl,
  input wire logic [3:0] rx_d,
  // Core side
  input wire logic link_up,
  input wire logic full_duplex,
  input wire logic tx_out_valid,
  input wire rgp_sym_t tx_out_sym,
  input wire logic tx_frame
);
  // =====
  // Rules
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rise; $rose(tx_clk); endsequence
  sequence s_fall; $fell(tx_clk); endsequence
  a_rx_clk_run: assert property (RX_HALF == 1 && $past(rst_n, 4) |-> $changed(rx_clk))
    else $error("rx_clk stalled");
  a_edge_align: assert property (!$changed(rx_clk) |-> $stable(rx_ctl) && $stable(rx_d))
    else $error("rx pins off edge");
  a_status_bits: assert property ($rose(rx_clk) && !rx_ctl && rx_d != FALSE_CARRIER_NIB
    |-> rx_d == {$past(full_duplex), 2'b00, $past(link_up)})
    else $error("bad status nibble");
  a_fc_pair: assert property ($fell(rx_clk) && rx_ctl && !$past(rx_ctl)
    |-> rx_d == FALSE_CARRIER_NIB && $past(rx_d) == FALSE_CARRIER_NIB)
    else $error("reserved rx code");
  a_idle_pair: assert property ($fell(rx_clk) && !rx_ctl && !$past(rx_ctl) |-> $stable(rx_d))
    else $error("status halves differ");
  a_tx_pulse: assert property (tx_out_valid |=> (!tx_out_valid) [*8])
    else $error("tx valid too long");
  a_tx_hold: assert property (!tx_out_valid |-> $stable(tx_out_sym) && $stable(tx_frame))
    else $error("tx output moved");
  a_tx_frame: assert property (tx_out_valid |-> tx_frame == (tx_out_sym.kind != RGP_IDLE))
    else $error("tx frame wrong");
  a_tx_answer: assert property (s_rise ##[1:30] s_fall |-> ##[1:6] tx_out_valid)
    else $error("tx period lost");
endmodule
bind rgp_top rgp_top_assertions #(.RX_HALF(RX_HALF), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .clk_sys, .rst_n, .tx_clk, .rx_clk, .rx_ctl, .rx_d, .link_up, .full_duplex,
  .tx_out_valid, .tx_out_sym, .tx_frame);
`default_nettype wire

// ===== testbench/rgp_mac_model.sv
// Behavioural MAC facing the device pins
`timescale 1ns/100ps
`default_nettype none
module rgp_mac_model
  import rgp_pkg::*;
(
  // Pacing clock
  input wire logic clk_sys,
  // Transmit pins
  output logic tx_clk,
  output logic tx_ctl,
  output logic [3:0] tx_d,
  // Receive pins
  input wire logic rx_clk,
  input wire logic rx_ctl,
  input wire logic [3:0] rx_d
);
  logic [9:0] rx_q[$];
  logic [3:0] stat_r = NIB_ZERO;
  logic c1, c2;
  logic [3:0] lo, hi;

  // =============
  // Transmit side
  initial begin
    tx_clk = 1'b0;
    tx_ctl = 1'b0;
    tx_d = NIB_ZERO;
  end

  // one period, low nibble and first value at the rise
  task automatic send(input logic k1, input logic k2, input logic [7:0] d);
    tx_ctl <= k1;
    tx_d <= d[3:0];
    repeat (10) @(posedge clk_sys);
    tx_clk <= 1'b1;
    repeat (10) @(posedge clk_sys);
    tx_ctl <= k2;
    tx_d <= d[7:4];
    repeat (10) @(posedge clk_sys);
    tx_clk <= 1'b0;
    repeat (5) @(posedge clk_sys);
    // Released lines show the inverse, clock stands still
    tx_ctl <= ~k2;
    tx_d <= ~d[7:4];
    repeat (5) @(posedge clk_sys);
  endtask

  // ============
  // Receive side
  // both halves, keep status, drop reserved codes
  always begin
    @(posedge rx_clk);
    #1;
    c1 = rx_ctl;
    lo = rx_d;
    @(negedge rx_clk);
    #1;
    c2 = rx_ctl;
    hi = rx_d;
    if (!c1 && !c2) begin
      stat_r = lo;
    end else if (c1 || {hi, lo} == 8'hEE) begin
      rx_q.push_back({c1, c2, hi, lo});
    end
  end
endmodule
`default_nettype wire

// ===== testbench/test_rgp_top.sv
// Self-checking bench for the reduced gigabit interface
`timescale 1ns/100ps
`default_nettype none
module test_rgp_top
  import rgp_pkg::*;
;
  typedef struct packed {
    logic c1;
    logic c2;
    logic [7:0] d;
    rgp_kind_t tk;
    rgp_kind_t rk;
  } rgp_row_t;
  localparam rgp_row_t ROWS[4] = '{
    '{1'b1, 1'b0, 8'hA5, RGP_DATA, RGP_DATA},
    '{1'b1, 1'b1, 8'h5A, RGP_ERR, RGP_ERR},
    '{1'b0, 1'b1, 8'hEE, RGP_IDLE, RGP_FALSE_CARRIER},
    '{1'b0, 1'b0, 8'h3C, RGP_IDLE, RGP_IDLE}};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic link_up = 1'b0;
  logic full_duplex = 1'b0;
  logic rx_in_valid = 1'b0;
  rgp_sym_t rx_in_sym = '0;
  logic tx_clk, tx_ctl, rx_clk, rx_ctl, rx_in_ready, tx_out_valid, tx_frame;
  logic [3:0] tx_d, rx_d;
  rgp_sym_t tx_out_sym, tx_seen;
  int n_fail = 0;
  int check_count = 0;
  int tx_cnt = 0;
  int cyc = 0;
  int nref = 0;

  // ===================
  // Design and MAC side
  rgp_top #(.RX_HALF(1), .FIFO_DEPTH(16)) i_rgp_top (
    .clk_sys, .rst_n, .tx_clk, .tx_ctl, .tx_d, .rx_clk, .rx_ctl, .rx_d, .link_up,
    .full_duplex, .rx_in_valid, .rx_in_sym, .rx_in_ready, .tx_out_valid, .tx_out_sym,
    .tx_frame);
  rgp_mac_model i_rgp_mac_model (.clk_sys, .tx_clk, .tx_ctl, .tx_d, .rx_clk, .rx_ctl, .rx_d);

  // 250 MHz system clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Capture decoded periods, watchdog
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (tx_out_valid === 1'b1) begin
      tx_seen <= tx_out_sym;
      tx_cnt <= tx_cnt + 1;
    end
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end

  // Offer one receive word and hold it until taken
  task automatic offer(input rgp_sym_t s);
    int w;
    w = 0;
    rx_in_valid <= 1'b1;
    rx_in_sym <= s;
    do begin
      @(posedge clk_sys);
      w++;
      if (rx_in_ready !== 1'b1) nref++;
    end while (rx_in_ready !== 1'b1 && w < 200);
  endtask

  // Oldest period seen by the MAC, all ones if none
  function automatic logic [15:0] pop();
    if (i_rgp_mac_model.rx_q.size() == 0) return 16'hFFFF;
    return 16'(i_rgp_mac_model.rx_q.pop_front());
  endfunction

  // Hold reset five cycles and check quiet outputs
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check("reset", 16'({rx_clk, rx_ctl, rx_d, rx_in_ready, tx_out_valid, tx_frame}), 16'h0000);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  // Main sequence
  initial begin
    int c0;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      link_up <= i[0];
      full_duplex <= i[1];
      c0 = tx_cnt;
      i_rgp_mac_model.send(ROWS[i].c1, ROWS[i].c2, ROWS[i].d);
      check("tx sym", 16'(tx_seen), 16'({ROWS[i].tk, ROWS[i].d}));
      check("tx count", 16'(tx_cnt - c0), 16'h0001);
      check("tx frame", 16'(tx_frame), 16'(ROWS[i].tk != RGP_IDLE));
      check("status", 16'(i_rgp_mac_model.stat_r), 16'({i[1], 2'b00, i[0]}));
      offer({ROWS[i].rk, ROWS[i].d});
      rx_in_valid <= 1'b0;
      repeat (12) @(posedge clk_sys);
      c0 = ROWS[i].rk == RGP_IDLE ? 16'hFFFF : 16'({ROWS[i].c1, ROWS[i].c2, ROWS[i].d});
      check("rx pins", pop(), 16'(c0));
    end
    // 48 back-to-back words, some refused while full, then drained in order
    nref = 0;
    for (int i = 0; i < 48; i++) offer({RGP_DATA, 8'(i * 7)});
    rx_in_valid <= 1'b0;
    repeat (120) @(posedge clk_sys);
    check("refused", 16'(nref > 0), 16'h0001);
    for (int i = 0; i < 48; i++) check("fill", pop(), 16'({2'b10, 8'(i * 7)}));
    check("status back", 16'(i_rgp_mac_model.stat_r), 16'h0009);
    // Reset in mid-frame drops the pending word
    i_rgp_mac_model.send(1'b1, 1'b0, 8'h96);
    offer({RGP_ERR, 8'h33});
    rx_in_valid <= 1'b0;
    do_reset();
    repeat (12) @(posedge clk_sys);
    check("after reset", pop(), 16'hFFFF);
    test_done();
  end
endmodule
`default_nettype wire
